// ### hdl/cwd_watchdog.sv
`timescale 1ns/1ps
// Function
// - free-running 6-bit watchdog counter fed by a 12-bit prescaler
// - unserviced overflow resets after short or long timeout by config bit
// - any write to service register clears counter and prescaler bits 4 and up
// - service address reads back reset vector low byte, never watchdog state
// - watchdog reset drives reset pin low 32 cycles and sets cause bit
// - monitor mode with high voltage on reset or interrupt pin disables watchdog
// - break state with high voltage on reset pin disables watchdog
// - STOP instruction clears the prescaler
// - internal reset clears prescaler and watchdog counter
// - reset vector fetch clears the prescaler
// - disable config bit stops watchdog from generating a reset
// - no CPU interrupt or DMA requests; only action is reset
// - counting continues during wait mode
// - stop mode halts counting and clears prescaler until stop ends
// - STOP honoured only when stop-enable config bit is set
`include "cwd_regs.svh"
module cwd_watchdog
    import cwd_pkg::*;
#(
    parameter int         PRE_W        = 12,
    parameter int         WD_W         = 6,
    parameter logic [7:0] RESET_VEC_LO = 8'h00
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        monitor_mode,
    input  wire logic        break_state,
    input  wire logic        hv_rst_pin,
    input  wire logic        external_interrupt_hv_pin,
    input  wire logic        internal_reset,
    input  wire logic        vector_fetch,
    input  wire logic        stop_exec,
    input  wire logic        stop_wake,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    output logic             stop_active,
    output logic             sys_event
);

    initial begin
        if (PRE_W <= `CWD_SHORT_TAP_MSB || PRE_W > 16 || WD_W < 1 || WD_W > 16) begin
            $error("cwd_watchdog: unsupported counter widths");
        end
    end

    // pin synchronisers
    logic [1:0] hv_rst_sync_q;
    logic [1:0] hv_irq_sync_q;
    logic       hv_rst_s;
    logic       hv_irq_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hv_rst_sync_q <= 2'h0;
            hv_irq_sync_q <= 2'h0;
        end else begin
            hv_rst_sync_q <= {hv_rst_sync_q[0], hv_rst_pin};
            hv_irq_sync_q <= {hv_irq_sync_q[0], external_interrupt_hv_pin};
        end
    end
    assign hv_rst_s = hv_rst_sync_q[1];
    assign hv_irq_s = hv_irq_sync_q[1];

    // bus slave state
    cwd_addr_t                ap_q,   ap_d;
    logic      [31:0]         rdata_q, rdata_d;
    cwd_cfg_t                 cfg_q,  cfg_d;
    logic      [`CWD_EVT_W-1:0] stat_q, stat_d;
    logic      [`CWD_EVT_W-1:0] en_q,   en_d;
    logic                     irq_q,  irq_d;

    // counting state
    logic      [PRE_W-1:0]    pre_q,  pre_d;
    logic      [WD_W-1:0]     wd_q,   wd_d;
    cwd_state_t               st_q,   st_d;
    logic      [5:0]          pls_q,  pls_d;
    logic                     stop_q, stop_d;
    logic                     oe_q,   oe_d;

    logic wd_off;
    logic tap;
    logic svc_wr;
    logic ovf;
    logic [`CWD_EVT_W-1:0] evt_set;
    logic [`CWD_EVT_W-1:0] evt_clr;

    // hv gating is purely combinational after the synchronisers
    assign wd_off = cfg_q.wd_disable
                  | (monitor_mode & (hv_rst_s | hv_irq_s))
                  | (break_state & hv_rst_s);

    assign svc_wr = ap_q.valid & ap_q.write & (ap_q.idx == `CWD_SERVICE_IDX);

    // tap: low seven bits wrap (short) or whole prescaler wraps (long)
    always_comb begin
        if (cfg_q.long_timeout_select) begin
            tap = &pre_q;
        end else begin
            tap = &pre_q[`CWD_SHORT_TAP_MSB:0];
        end
    end

    assign ovf = tap & (&wd_q) & !wd_off & (st_q == CWD_RUN) & !stop_q;

    // bus address and read data
    always_comb begin
        ap_d    = '0;
        rdata_d = rdata_q;
        if (hsel && htrans[1] && hready) begin
            ap_d.valid = 1'b1;
            ap_d.write = hwrite;
            ap_d.idx   = haddr[31:2];
            rdata_d    = 32'h0;
            if (!hwrite) begin
                case (haddr[31:2])
                    `CWD_SERVICE_IDX: rdata_d = {24'h0, RESET_VEC_LO};
                    `CWD_CFG_IDX:     rdata_d = {29'h0, cfg_q};
                    `CWD_STATUS_IDX:  rdata_d = {30'h0, stat_q};
                    `CWD_EVT_EN_IDX:  rdata_d = {30'h0, en_q};
                    `CWD_COUNT_IDX: begin
                        rdata_d[PRE_W-1:0]                     = pre_q;
                        rdata_d[`CWD_CNT_WD_LSB +: WD_W]       = wd_q;
                    end
                    default:          rdata_d = 32'h0;
                endcase
            end
        end
    end

    // registers, events and the system event line
    always_comb begin
        cfg_d   = cfg_q;
        en_d    = en_q;
        evt_clr = '0;
        evt_set = '0;
        if (ap_q.valid && ap_q.write) begin
            case (ap_q.idx)
                `CWD_CFG_IDX:     cfg_d   = hwdata[`CWD_CFG_W-1:0];
                `CWD_EVT_EN_IDX:  en_d    = hwdata[`CWD_EVT_W-1:0];
                `CWD_EVT_CLR_IDX: evt_clr = hwdata[`CWD_EVT_W-1:0];
                default:          evt_clr = '0;
            endcase
        end
        evt_set[`CWD_EVT_TIMEOUT] = ovf;
        evt_set[`CWD_EVT_SERVICE] = svc_wr;
        stat_d = (stat_q & ~evt_clr) | evt_set;
        // goes to reset-cause logic, not to the CPU interrupt controller
        irq_d  = |(stat_d & en_d);
    end

    // prescaler, watchdog counter, reset pulse, stop
    always_comb begin
        pre_d  = pre_q + PRE_W'(1);
        wd_d   = wd_q;
        st_d   = st_q;
        pls_d  = pls_q;
        stop_d = stop_q;
        if (tap) begin
            wd_d = wd_q + WD_W'(1);
        end
        if (stop_exec && cfg_q.stop_en) begin
            stop_d = 1'b1;
        end else if (stop_wake) begin
            stop_d = 1'b0;
        end
        if (svc_wr) begin
            wd_d = '0;
            pre_d[PRE_W-1:`CWD_SVC_KEEP_LSB] = '0;
        end
        if (stop_exec || stop_q) begin
            pre_d = '0;
            wd_d  = (svc_wr) ? '0 : wd_q;
        end
        if (vector_fetch) begin
            pre_d = '0;
        end
        if (wd_off) begin
            pre_d = '0;
            wd_d  = '0;
        end
        case (st_q)
            CWD_RUN: begin
                if (ovf) begin
                    st_d  = CWD_PULSE;
                    pls_d = `CWD_RST_PULSE_CYC - 6'h01;
                    stop_d = 1'b0;
                end
            end
            CWD_PULSE: begin
                pre_d = '0;
                wd_d  = '0;
                if (pls_q == 6'h00) begin
                    st_d = CWD_RUN;
                end else begin
                    pls_d = pls_q - 6'h01;
                end
            end
            default: begin
                st_d = CWD_RUN;
            end
        endcase
        if (internal_reset) begin
            pre_d = '0;
            wd_d  = '0;
        end
        oe_d = (st_d == CWD_PULSE);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q    <= '0;
            rdata_q <= 32'h0;
            cfg_q   <= `CWD_CFG_RESET;
            stat_q  <= `CWD_EVT_RESET;
            en_q    <= `CWD_EVT_RESET;
            irq_q   <= 1'b0;
            pre_q   <= '0;
            wd_q    <= '0;
            st_q    <= CWD_RUN;
            pls_q   <= 6'h00;
            stop_q  <= 1'b0;
            oe_q    <= 1'b0;
        end else begin
            ap_q    <= ap_d;
            rdata_q <= rdata_d;
            cfg_q   <= cfg_d;
            stat_q  <= stat_d;
            en_q    <= en_d;
            irq_q   <= irq_d;
            pre_q   <= pre_d;
            wd_q    <= wd_d;
            st_q    <= st_d;
            pls_q   <= pls_d;
            stop_q  <= stop_d;
            oe_q    <= oe_d;
        end
    end

    assign hrdata      = rdata_q;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe  = oe_q;
    assign stop_active = stop_q;
    assign sys_event   = irq_q;

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    svc_clears_both_a: assert property (svc_wr && !wd_off |=> wd_q == '0
        && pre_q[PRE_W-1:`CWD_SVC_KEEP_LSB] == '0)
        else $error("service write did not clear counters");
    svc_read_vector_a: assert property (hsel && htrans[1] && hready && !hwrite
        && haddr[31:2] == `CWD_SERVICE_IDX |=> hrdata == {24'h0, RESET_VEC_LO})
        else $error("service address read wrong data");
    rst_pulse_len_a: assert property ($rose(rst_pin_oe) |-> ##31 rst_pin_oe ##1 !rst_pin_oe)
        else $error("reset pulse not 32 cycles");
    cause_bit_set_a: assert property ($rose(rst_pin_oe) |-> stat_q[`CWD_EVT_TIMEOUT])
        else $error("cause bit not set with reset");
    disabled_no_rst_a: assert property (wd_off |=> !$rose(rst_pin_oe))
        else $error("reset while disabled");
    break_hv_off_a: assert property (break_state && hv_rst_s |-> wd_off)
        else $error("break high voltage did not disable");
    stop_holds_pre_a: assert property (stop_q |-> pre_q == '0)
        else $error("prescaler ran in stop");
    stop_exec_clear_a: assert property (stop_exec |=> pre_q == '0)
        else $error("stop did not clear prescaler");
    int_reset_clear_a: assert property (internal_reset |=> pre_q == '0 && wd_q == '0)
        else $error("internal reset did not clear");
    vec_fetch_clear_a: assert property (vector_fetch |=> pre_q == '0)
        else $error("vector fetch did not clear");
    cfg_disable_a: assert property (cfg_q.wd_disable |=> !$rose(rst_pin_oe))
        else $error("reset while config disabled");
    off_holds_zero_a: assert property (wd_off
        |=> wd_q == '0 && pre_q == '0)
        else $error("disabled watchdog kept counting");
    okay_resp_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus response not okay");
    wait_counts_a: assert property (!stop_q && !stop_exec && !wd_off
        && st_q == CWD_RUN && !internal_reset && !vector_fetch && !svc_wr
        && !(&pre_q) |=> pre_q == $past(pre_q) + PRE_W'(1))
        else $error("prescaler did not advance");
    stop_freeze_a: assert property (stop_q && !svc_wr && !wd_off
        && !internal_reset && st_q == CWD_RUN |=> $stable(wd_q))
        else $error("watchdog counted in stop");
    sys_event_lvl_a: assert property (sys_event == |(stat_q & en_q))
        else $error("system event line wrong");
    stop_gated_a: assert property (stop_exec && !cfg_q.stop_en && !stop_q
        && !internal_reset |=> !stop_q)
        else $error("stop honoured while not enabled");
    wd_step_tap_a: assert property ($changed(wd_q) && wd_q != '0 |-> $past(tap))
        else $error("watchdog stepped without tap");
    overflow_rst_a: assert property (ovf |=> rst_pin_oe)
        else $error("overflow did not reset");

    timeout_c: cover property ($rose(rst_pin_oe));
    service_c: cover property (svc_wr ##1 wd_q == '0);
    stop_c:    cover property ($rose(stop_q) ##[1:20] $fell(stop_q));
    long_c:    cover property (cfg_q.long_timeout_select && tap);
    off_c:     cover property (wd_off ##1 !wd_off);

endmodule

// ### hdl/cwd_regs.svh
`ifndef CWD_REGS_SVH
`define CWD_REGS_SVH

// word indices; the byte address is four times the index
`define CWD_SERVICE_IDX   30'h0000FFFF
`define CWD_CFG_IDX       30'h00000000
`define CWD_STATUS_IDX    30'h00000001
`define CWD_EVT_EN_IDX    30'h00000002
`define CWD_EVT_CLR_IDX   30'h00000003
`define CWD_COUNT_IDX     30'h00000004

// configuration bits
`define CWD_CFG_LONG_BIT  0
`define CWD_CFG_DIS_BIT   1
`define CWD_CFG_STOP_BIT  2
`define CWD_CFG_W         3
`define CWD_CFG_RESET     3'h0

// event bits
`define CWD_EVT_TIMEOUT   0
`define CWD_EVT_SERVICE   1
`define CWD_EVT_W         2
`define CWD_EVT_RESET     2'h0

// prescaler taps and partial clear
`define CWD_SHORT_TAP_MSB 6
`define CWD_SVC_KEEP_LSB  4

// reset pin pulse, crystal clock cycles
`define CWD_RST_PULSE_CYC 6'h20

// count register layout
`define CWD_CNT_WD_LSB    16

`endif

// ### hdl/cwd_pkg.sv
package cwd_pkg;

    typedef enum logic [0:0] {
        CWD_RUN,
        CWD_PULSE
    } cwd_state_t;

    typedef struct packed {
        logic stop_en;
        logic wd_disable;
        logic long_timeout_select;
    } cwd_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [29:0] idx;
    } cwd_addr_t;

endpackage

// ### tb/cwd_sys_model.sv
`timescale 1ns/1ps
module cwd_sys_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       rst_pin_oe,
    output logic      [7:0] pulse_len,
    output int              pulse_cnt
);
    logic [7:0] run_q;

    // length of each low pulse on the reset pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q     <= 8'h00;
            pulse_len <= 8'h00;
            pulse_cnt <= 0;
        end else if (rst_pin_oe) begin
            run_q <= run_q + 8'h01;
        end else if (run_q != 8'h00) begin
            pulse_len <= run_q;
            pulse_cnt <= pulse_cnt + 1;
            run_q     <= 8'h00;
        end
    end
endmodule

// ### tb/tb_cop_watchdog_timer.sv
`timescale 1ns/1ps
module tb_cop_watchdog_timer;
    localparam logic [7:0]  VEC_LO = 8'hA5;
    localparam logic [31:0] SVC    = 32'h0003FFFC;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dp_rd = 0;
    logic        monitor_mode = 0, break_state = 0, hv_rst_pin = 0;
    logic        external_interrupt_hv_pin = 0, internal_reset = 0, vector_fetch = 0;
    logic        stop_exec = 0, stop_wake = 0;
    logic [31:0] haddr = 0, hwdata = 0, rnd = 32'd72953;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hrdata;
    logic        hready, hresp, rst_pin_out, rst_pin_oe, stop_active, sys_event;
    logic [7:0]  pulse_len;
    int          pulse_cnt, err_total = 0, n_compared = 0, h;
    logic [31:0] exp_q[$];

    always #12.5 hclk = ~hclk;

    cwd_watchdog #(.RESET_VEC_LO(VEC_LO)) cwd_watchdog_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .monitor_mode(monitor_mode), .break_state(break_state), .hv_rst_pin(hv_rst_pin),
        .external_interrupt_hv_pin(external_interrupt_hv_pin),
        .internal_reset(internal_reset), .vector_fetch(vector_fetch),
        .stop_exec(stop_exec), .stop_wake(stop_wake), .rst_pin_out(rst_pin_out),
        .rst_pin_oe(rst_pin_oe), .stop_active(stop_active), .sys_event(sys_event));

    cwd_sys_model cwd_sys_model_i (.hclk(hclk), .hresetn(hresetn), .rst_pin_oe(rst_pin_oe),
        .pulse_len(pulse_len), .pulse_cnt(pulse_cnt));

    function logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task complete_run;
        $display("mismatches %0d of %0d compared", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
    endtask

    task rd(input logic [31:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        xfer(1'b0, a, 32'h0);
    endtask

    task quiet(input int n, output int hits);
        hits = 0;
        repeat (n) begin
            @(posedge hclk);
            if (rst_pin_oe !== 1'b0) hits++;
        end
    endtask

    task pulse(input logic wake);
        if (wake) stop_wake <= 1'b1;
        else stop_exec <= 1'b1;
        @(posedge hclk);
        stop_wake <= 1'b0;
        stop_exec <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // read data checked one cycle after the address phase
    always @(posedge hclk) begin
        if (dp_rd && hready === 1'b1) begin
            if (exp_q.size() == 0)
                chk("unexpected_read", 32'h0, 32'h1);
            else
                chk("hrdata", hrdata, exp_q.pop_front());
            chk("hresp", {31'h0, hresp}, 32'h0);
        end
        dp_rd <= hsel & htrans[1] & ~hwrite & hready;
    end

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(32'h00000000, 32'h00000000);
        rd(32'h00000004, 32'h00000000);
        rd(SVC, {24'h000000, VEC_LO});
        rd(32'h00001000 | (xs() & 32'h00000FFC), 32'h00000000);
        xfer(1'b1, SVC, xs());
        quiet(8100, h);
        chk("early_reset", h, 0);
        h = 0;
        while (rst_pin_oe !== 1'b1 && h < 600) begin
            @(posedge hclk);
            h++;
        end
        chk("timeout_seen", {31'h0, h < 600}, 32'h1);
        chk("rst_pin_low", {31'h0, rst_pin_out}, 32'h0);
        repeat (40) @(posedge hclk);
        chk("pulse_len", {24'h0, pulse_len}, 32'h20);
        chk("pulse_cnt", pulse_cnt, 1);
        rd(32'h00000004, 32'h00000003);
        chk("event_masked", {31'h0, sys_event}, 32'h0);
        xfer(1'b1, 32'h00000008, 32'h00000001);
        repeat (2) @(posedge hclk);
        chk("event_on", {31'h0, sys_event}, 32'h1);
        xfer(1'b1, 32'h0000000C, 32'h00000003);
        repeat (2) @(posedge hclk);
        chk("event_off", {31'h0, sys_event}, 32'h0);
        rd(32'h00000004, 32'h00000000);
        repeat (3) begin
            xfer(1'b1, SVC, xs());
            quiet(4000, h);
            chk("serviced", h, 0);
        end
        internal_reset <= 1'b1;
        vector_fetch   <= 1'b1;
        rd(32'h00000010, 32'h00000000);
        internal_reset <= 1'b0;
        vector_fetch   <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            xfer(1'b1, 32'h00000000, (k == 0) ? 32'h00000002 : 32'h00000000);
            monitor_mode              <= (k == 1);
            external_interrupt_hv_pin <= (k == 1);
            break_state               <= (k == 2);
            hv_rst_pin                <= (k == 2);
            xfer(1'b1, SVC, xs());
            quiet(9000, h);
            chk("disabled", h, 0);
            {monitor_mode, external_interrupt_hv_pin, break_state, hv_rst_pin} <= 4'h0;
            xfer(1'b1, 32'h00000000, 32'h00000000);
            xfer(1'b1, SVC, xs());
        end
        xfer(1'b1, 32'h00000000, 32'h00000001);
        xfer(1'b1, SVC, xs());
        quiet(9000, h);
        chk("long_timeout", h, 0);
        xfer(1'b1, 32'h00000000, 32'h00000000);
        xfer(1'b1, SVC, xs());
        pulse(1'b0);
        chk("stop_refused", {31'h0, stop_active}, 32'h0);
        xfer(1'b1, 32'h00000000, 32'h00000004);
        pulse(1'b0);
        chk("stop_on", {31'h0, stop_active}, 32'h1);
        quiet(9000, h);
        chk("stop_halt", h, 0);
        pulse(1'b1);
        chk("stop_off", {31'h0, stop_active}, 32'h0);
        xfer(1'b1, SVC, xs());
        complete_run;
    end

    initial begin
        #(100000 * 25);
        err_total++;
        complete_run;
    end
endmodule
